// [core/ata_command_handler.v]
/*
 * Task file and command sequencer for power query, diagnostics, sector
 * erase, cache flush and track format. Assumes a synchronous 8-bit task
 * file port with one-cycle write/read strobes, and a media engine that
 * acknowledges each sector operation and cache commit with pulses.
 */
`timescale 1ns/1ps
`include "ata_cmd_defs.vh"

// Function
// R1: a sector count of zero means 256 sectors, any other value its own number.
// R2: the low four bits of the drive select register give a head 0 to 15.
// R3: a power query while asleep or in transition sets busy, loads count 00h, clears busy and interrupts.
// R4: a power query while idle sets busy, loads count FFh, clears busy and interrupts.
// R5: in card modes diagnostics run only when the drive bit selects this card.
// R6: in the fixed disk mode diagnostics ignore the drive bit and the master reports both drives; the master here flags a failed slave only if it passes.
// R7: diagnostics end with a result code 01h to 05h or 8Xh in the error register.
// R8: sector erase pre-erases each addressed sector for later writes without erase.
// R9: sector erase moves no host data but may end with write fault.
// R10: drive select holds 1, lba flag, 1, drive bit and address 27-24, the other fields address 23-0.
// R11: cache flush completes with ready and seek-complete only after the cache is committed.
// R12: a card without cache flushing aborts the flush command.
// R13: track format fills the addressed head and cylinder with a fixed pattern.
// R14: after track format the host writes one sector buffer that the card accepts and drops.
// R15: in lba mode track format takes its sector count from the count field, zero meaning 256.
// R16: hosts are advised not to issue track format, but the card still runs it.
module ata_command_handler #(
    parameter FLUSH_SUPPORTED = 1,
    parameter [7:0] FORMAT_PATTERN = 8'hff,
    parameter BUFFER_BYTES = 512
) (
    input wire clk_sys, // system clock, 20 MHz
    input wire sys_rst, // async reset, high
    input wire [2:0] tf_addr, // task file offset
    input wire [7:0] tf_wdata, // write data
    input wire tf_wr, // write strobe
    input wire tf_rd, // read strobe
    output reg [7:0] tf_rdata, // read data, one cycle after tf_rd
    input wire ide_mode, // 1 = fixed disk mode, 0 = card modes
    input wire is_master, // 1 = this card is the master, drive 0, in fixed disk mode
    input wire slave_failed, // slave reported fault in fixed disk mode
    input wire sleep_state, // asleep, entering or leaving sleep
    input wire [3:0] fault, // self-test fault levels
    output reg media_req, // media operation request, level
    output reg [1:0] media_op, // 0 erase, 1 format fill, 2 flush
    output reg [27:0] media_lba, // sector address or chs packed
    output reg [7:0] media_fill, // fill pattern for format
    input wire media_ack, // operation done pulse
    input wire media_fail, // write fault with ack
    output reg intrq // interrupt request, cleared on status read
);
    localparam S_IDLE = 3'h0;
    localparam S_DIAG = 3'h1;
    localparam S_MEDIA = 3'h2;
    localparam S_DRAIN = 3'h3;
    localparam S_DONE = 3'h4;
    localparam [31:0] LAST_BYTE_WIDE = BUFFER_BYTES - 1;
    localparam [9:0] LAST_BYTE = LAST_BYTE_WIDE[9:0];

    reg [7:0] feature_reg;
    reg [7:0] sector_count_reg;
    reg [7:0] sector_number_reg;
    reg [7:0] cylinder_low_reg;
    reg [7:0] cylinder_high_reg;
    reg [7:0] drive_select_reg;
    reg [7:0] opcode_reg;
    reg [7:0] error_reg;
    reg [7:0] status_reg;
    reg [2:0] state;
    reg [9:0] drain_cnt;
    reg fault_seen;

    wire [3:0] head_field = drive_select_reg[3:0]; // see R2
    wire lba_mode = drive_select_reg[`DS_LBA];
    wire drive_bit = drive_select_reg[`DS_DRIVE];
    wire [27:0] address = {head_field, cylinder_high_reg, cylinder_low_reg, sector_number_reg}; // see R10
    wire selected = ide_mode ? (drive_bit == ~is_master) : 1'b1;
    wire cmd_wr = tf_wr && tf_addr == `OFS_OPCODE;
    wire busy = status_reg[`ST_BUSY];

    wire diag_start = cmd_wr && !busy && tf_wdata == `OP_DIAGNOSE && (ide_mode || !drive_bit); // see R5 see R6
    wire diag_done;
    wire [7:0] diag_code;
    wire cnt_load = cmd_wr && !busy && (tf_wdata == `OP_ERASE || tf_wdata == `OP_FORMAT);
    wire [7:0] fmt_count = lba_mode ? sector_count_reg : 8'h01; // see R15
    wire [7:0] cnt_value = (tf_wdata == `OP_FORMAT) ? fmt_count : sector_count_reg;
    wire cnt_step = state == S_MEDIA && media_ack && media_op != 2'h2;
    wire [8:0] remaining;
    wire cnt_last;

    sector_counter u_count (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .load(cnt_load),
        .count_in(cnt_value),
        .step(cnt_step),
        .remaining(remaining),
        .last(cnt_last)
    );

    self_test u_diag (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .start(diag_start),
        .fault(fault),
        .done(diag_done),
        .code(diag_code)
    );

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            feature_reg <= 8'h00;
            sector_count_reg <= 8'h01;
            sector_number_reg <= 8'h01;
            cylinder_low_reg <= 8'h00;
            cylinder_high_reg <= 8'h00;
            drive_select_reg <= `DS_ONES;
            opcode_reg <= 8'h00;
            error_reg <= `DIAG_OK;
            status_reg <= `STATUS_IDLE;
            state <= S_IDLE;
            drain_cnt <= 10'h000;
            fault_seen <= 1'b0;
            media_req <= 1'b0;
            media_op <= 2'h0;
            media_lba <= 28'h0000000;
            media_fill <= 8'h00;
            intrq <= 1'b0;
            tf_rdata <= 8'h00;
        end else begin
            tf_rdata <= 8'h00;
            if (tf_rd) begin
                case (tf_addr)
                    `OFS_FEATURE: tf_rdata <= error_reg;
                    `OFS_SECTOR_COUNT: tf_rdata <= sector_count_reg;
                    `OFS_SECTOR_NUMBER: tf_rdata <= sector_number_reg;
                    `OFS_CYLINDER_LOW: tf_rdata <= cylinder_low_reg;
                    `OFS_CYLINDER_HIGH: tf_rdata <= cylinder_high_reg;
                    `OFS_DRIVE_SELECT: tf_rdata <= drive_select_reg;
                    `OFS_OPCODE: tf_rdata <= status_reg;
                    default: tf_rdata <= 8'h00;
                endcase
            end
            // status read acknowledges the interrupt; a new one in the same cycle wins below
            if (tf_rd && tf_addr == `OFS_OPCODE) begin
                intrq <= 1'b0;
            end
            // task file writes are ignored while busy so a running command keeps its operands
            if (tf_wr && !busy) begin
                case (tf_addr)
                    `OFS_FEATURE: feature_reg <= tf_wdata;
                    `OFS_SECTOR_COUNT: sector_count_reg <= tf_wdata;
                    `OFS_SECTOR_NUMBER: sector_number_reg <= tf_wdata;
                    `OFS_CYLINDER_LOW: cylinder_low_reg <= tf_wdata;
                    `OFS_CYLINDER_HIGH: cylinder_high_reg <= tf_wdata;
                    `OFS_DRIVE_SELECT: drive_select_reg <= tf_wdata;
                    `OFS_OPCODE: opcode_reg <= tf_wdata;
                    default: feature_reg <= feature_reg;
                endcase
            end
            case (state)
                S_IDLE: begin
                    if (cmd_wr && !busy && (selected || tf_wdata == `OP_DIAGNOSE)) begin
                        status_reg[`ST_BUSY] <= 1'b1;
                        status_reg[`ST_ERR] <= 1'b0;
                        status_reg[`ST_WFAULT] <= 1'b0;
                        error_reg <= `ERR_NONE;
                        fault_seen <= 1'b0;
                        case (tf_wdata)
                            `OP_POWER_QUERY_A, `OP_POWER_QUERY_B: begin
                                sector_count_reg <= sleep_state ? `PWR_SLEEP_RESULT
                                                                : `PWR_IDLE_RESULT; // see R3 see R4
                                state <= S_DONE;
                            end
                            `OP_DIAGNOSE: begin
                                // in fixed disk mode the slave runs too but stays silent
                                state <= (ide_mode || !drive_bit) ? S_DIAG : S_IDLE; // see R5 see R6
                                if (!(ide_mode || !drive_bit)) begin
                                    // an unselected card leaves its status and error result as they were
                                    status_reg <= status_reg; // see R5
                                    error_reg <= error_reg;
                                end
                            end
                            `OP_ERASE: begin
                                media_op <= 2'h0;
                                media_lba <= address;
                                media_req <= 1'b1; // see R8 see R9
                                state <= S_MEDIA;
                            end
                            `OP_FORMAT: begin
                                media_op <= 2'h1;
                                media_lba <= address;
                                media_fill <= FORMAT_PATTERN; // see R13 see R16
                                media_req <= 1'b1;
                                state <= S_MEDIA;
                            end
                            `OP_FLUSH: begin
                                if (FLUSH_SUPPORTED != 0) begin
                                    media_op <= 2'h2;
                                    media_req <= 1'b1;
                                    state <= S_MEDIA;
                                end else begin
                                    error_reg <= `ERR_ABORT; // see R12
                                    status_reg[`ST_ERR] <= 1'b1;
                                    state <= S_DONE;
                                end
                            end
                            default: begin
                                error_reg <= `ERR_ABORT;
                                status_reg[`ST_ERR] <= 1'b1;
                                state <= S_DONE;
                            end
                        endcase
                    end
                end
                S_DIAG: begin
                    if (diag_done) begin
                        // a master with a passing code folds a failing slave into the high bit of its code
                        if (ide_mode && is_master && slave_failed && diag_code == `DIAG_OK) begin
                            error_reg <= `DIAG_SLAVE_FAIL | diag_code; // see R6 see R7
                        end else begin
                            error_reg <= diag_code; // see R7
                        end
                        state <= (ide_mode && !is_master) ? S_IDLE : S_DONE;
                        if (ide_mode && !is_master) begin
                            status_reg[`ST_BUSY] <= 1'b0;
                        end
                    end
                end
                S_MEDIA: begin
                    if (media_ack) begin
                        fault_seen <= fault_seen | media_fail;
                        if (media_op == 2'h2 || cnt_last) begin
                            media_req <= 1'b0; // see R11
                            if (media_op == 2'h1) begin
                                status_reg[`ST_DRQ] <= 1'b1; // see R14
                                drain_cnt <= 10'h000;
                                state <= S_DRAIN;
                            end else begin
                                state <= S_DONE;
                            end
                        end else begin
                            media_lba <= media_lba + 28'h0000001;
                        end
                    end
                end
                S_DRAIN: begin
                    // host data lands on the data port and is dropped
                    if (tf_wr && tf_addr == `OFS_DATA) begin
                        drain_cnt <= drain_cnt + 10'h001; // see R14
                        if (drain_cnt == LAST_BYTE) begin
                            status_reg[`ST_DRQ] <= 1'b0;
                            state <= S_DONE;
                        end
                    end
                end
                S_DONE: begin
                    status_reg[`ST_BUSY] <= 1'b0;
                    status_reg[`ST_READY] <= 1'b1; // see R11
                    status_reg[`ST_SEEKDONE] <= 1'b1;
                    if (fault_seen) begin
                        status_reg[`ST_WFAULT] <= 1'b1; // see R9
                        status_reg[`ST_ERR] <= 1'b1;
                        error_reg <= `ERR_ABORT;
                    end
                    intrq <= 1'b1; // see R3 see R4
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule // ata_command_handler

// [core/sector_counter.v]
/*
 * Down-counter of sectors for erase and format; a zero count loads 256.
 * Assumes one-cycle load and step pulses from the command sequencer.
 */
`timescale 1ns/1ps
`include "ata_cmd_defs.vh"

module sector_counter (
    input wire clk_sys, // system clock
    input wire sys_rst, // async reset, high
    input wire load, // load pulse
    input wire [7:0] count_in, // sector count field
    input wire step, // one sector done
    output reg [8:0] remaining, // sectors still to do
    output wire last // one sector left
);
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            remaining <= 9'h000;
        end else if (load) begin
            remaining <= (count_in == `ZERO_COUNT) ? `FULL_COUNT : {1'b0, count_in}; // see R1 see R15
        end else if (step && remaining != 9'h000) begin
            remaining <= remaining - 9'h001;
        end
    end

    assign last = (remaining == 9'h001);
endmodule // sector_counter

// [core/self_test.v]
/*
 * Diagnostic engine: walks four internal checks and yields a result code.
 * Assumes fault inputs are static levels from the rest of the card.
 */
`timescale 1ns/1ps
`include "ata_cmd_defs.vh"

module self_test (
    input wire clk_sys, // system clock
    input wire sys_rst, // async reset, high
    input wire start, // start pulse
    input wire [3:0] fault, // formatter, buffer, ecc, cpu faults
    output reg done, // result valid pulse
    output reg [7:0] code // first failing check code
);
    reg [2:0] step_idx;
    reg running;

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            step_idx <= 3'h0;
            running <= 1'b0;
            done <= 1'b0;
            code <= `ERR_NONE;
        end else begin
            done <= 1'b0;
            if (start) begin
                running <= 1'b1;
                step_idx <= 3'h0;
                code <= `DIAG_OK;
            end else if (running) begin
                if (fault[step_idx[1:0]]) begin
                    code <= {5'h00, step_idx} + 8'h02; // see R7
                    running <= 1'b0;
                    done <= 1'b1;
                end else if (step_idx == 3'h3) begin
                    running <= 1'b0;
                    done <= 1'b1;
                end else begin
                    step_idx <= step_idx + 3'h1;
                end
            end
        end
    end
endmodule // self_test

// [dv/ata_command_handler_asserts.sv]
/* Port checker for the command block, bound to every instance of it.
   Assumes the single 20 MHz clock and the async high reset of the block. */
`timescale 1ns/1ps
module ata_command_handler_asserts #(
    parameter FLUSH_SUPPORTED = 1,
    parameter [7:0] FORMAT_PATTERN = 8'hff,
    parameter BUFFER_BYTES = 512
) (
    input wire clk_sys, // system clock
    input wire sys_rst, // async reset, high
    input wire [2:0] tf_addr, // task file offset
    input wire [7:0] tf_wdata, // write data
    input wire tf_wr, // write strobe
    input wire tf_rd, // read strobe
    input wire [7:0] tf_rdata, // read data
    input wire media_req, // media request
    input wire [1:0] media_op, // media operation
    input wire [27:0] media_lba, // media address
    input wire [7:0] media_fill, // fill pattern
    input wire media_ack, // media done pulse
    input wire intrq // interrupt request
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence s_stat_rd;
        tf_rd && tf_addr == 3'h7;
    endsequence
    sequence s_query_wr;
        tf_wr && tf_addr == 3'h7 && (tf_wdata == 8'h98 || tf_wdata == 8'he5) && !media_req;
    endsequence
    a_rdata_idle: assert property (!tf_rd |=> tf_rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_query_irq: assert property (s_query_wr |-> ##2 intrq)
        else $error("power query did not interrupt in two cycles");
    a_irq_clear: assert property (s_stat_rd ##1 !tf_rdata[7] |-> !intrq)
        else $error("status read left interrupt pending");
    a_flush_ready: assert property (s_stat_rd ##1 (!tf_rdata[7] && !tf_rdata[5] && !tf_rdata[0])
        |-> tf_rdata[6] && tf_rdata[4])
        else $error("idle status without ready and seek done");
    a_req_hold: assert property (media_req && !media_ack |=> media_req)
        else $error("media request dropped before acknowledge");
    a_req_stable: assert property (media_req && !media_ack |=> $stable(media_lba) && $stable(media_op))
        else $error("media address or op moved while waiting");
    a_lba_step: assert property (media_req && media_ack ##1 media_req
        |-> media_lba == $past(media_lba) + 28'h1)
        else $error("media address did not advance by one");
    a_fill_fixed: assert property (media_req && media_op == 2'd1 |-> media_fill == FORMAT_PATTERN)
        else $error("format fill pattern wrong");
    a_flush_absent: assert property (media_req && media_op == 2'd2 |-> FLUSH_SUPPORTED != 0)
        else $error("flush reached media without flush support");
endmodule // ata_command_handler_asserts

bind ata_command_handler ata_command_handler_asserts #(
    .FLUSH_SUPPORTED(FLUSH_SUPPORTED), .FORMAT_PATTERN(FORMAT_PATTERN), .BUFFER_BYTES(BUFFER_BYTES)
) u_asserts (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .tf_addr(tf_addr), .tf_wdata(tf_wdata), .tf_wr(tf_wr),
    .tf_rd(tf_rd), .tf_rdata(tf_rdata), .media_req(media_req), .media_op(media_op),
    .media_lba(media_lba), .media_fill(media_fill), .media_ack(media_ack), .intrq(intrq)
);

// [dv/media_engine_model.sv]
/* Media engine stand-in: acknowledges each sector or commit after 2-4 cycles.
   Assumes the block holds media_req until its final acknowledge. */
`timescale 1ns/1ps
module media_engine_model (
    input wire clk_sys, // system clock
    input wire sys_rst, // async reset, high
    input wire media_req, // operation request
    input wire [27:0] media_lba, // sector address
    input wire fail_en, // report write fault
    output logic media_ack, // done pulse
    output logic media_fail, // fault, valid with ack
    output int acks, // acks in current request
    output logic [27:0] lba_first, // address at first ack
    output logic [27:0] lba_last // address at last ack
);
    int wait_cnt;
    logic req_q;
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            media_ack <= 1'b0;
            media_fail <= 1'b0;
            wait_cnt <= 0;
            req_q <= 1'b0;
            acks <= 0;
        end else begin
            req_q <= media_req;
            // fault line is only meaningful with ack, so it wanders otherwise
            media_fail <= 1'($urandom);
            if (media_req && !req_q) begin
                acks <= 0;
            end else if (media_ack) begin
                media_ack <= 1'b0;
            end else if (media_req) begin
                if (wait_cnt == 0) begin
                    media_ack <= 1'b1;
                    media_fail <= fail_en;
                    acks <= acks + 1;
                    if (acks == 0) lba_first <= media_lba;
                    lba_last <= media_lba;
                    wait_cnt <= $urandom % 3;
                end else begin
                    wait_cnt <= wait_cnt - 1;
                end
            end
        end
    end
endmodule // media_engine_model

// [dv/tb_ata_command_handler.sv]
/* Self-checking bench for the command block with a media engine model.
   Assumes a shortened sector buffer of 4 bytes. */
`timescale 1ns/1ps
module tb_ata_command_handler;
    localparam int BUF = 4;
    logic clk_sys = 1'b0, sys_rst = 1'b1, tf_wr = 1'b0, tf_rd = 1'b0, ide_mode = 1'b0, is_master = 1'b1;
    logic slave_failed = 1'b0, sleep_state = 1'b0, fail_en = 1'b0;
    logic [2:0] tf_addr = 3'h0;
    logic [7:0] tf_wdata = 8'h00, d, cnt;
    logic [3:0] fault = 4'h0;
    logic [27:0] lba, lba_first, lba_last;
    wire [7:0] tf_rdata, media_fill;
    wire [1:0] media_op;
    wire [27:0] media_lba;
    wire media_req, media_ack, media_fail, intrq;
    int acks, num_errors = 0, n_tests = 0, cyc = 0;
    int ra[5] = '{1, 2, 3, 6, 7};
    int rv[5] = '{8'h01, 8'h01, 8'h01, 8'ha0, 8'h50};

    always #25 clk_sys = ~clk_sys;

    // counts interrupt rising edges, since the polling status read clears each one quickly
    logic irq_q = 1'b0;
    int irqs = 0;
    always @(posedge clk_sys) begin
        irq_q <= intrq;
        if (intrq === 1'b1 && irq_q === 1'b0) irqs++;
    end

    ata_command_handler #(.BUFFER_BYTES(BUF)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .tf_addr(tf_addr),
        .tf_wdata(tf_wdata), .tf_wr(tf_wr), .tf_rd(tf_rd), .tf_rdata(tf_rdata), .ide_mode(ide_mode),
        .is_master(is_master), .slave_failed(slave_failed), .sleep_state(sleep_state), .fault(fault),
        .media_req(media_req), .media_op(media_op), .media_lba(media_lba), .media_fill(media_fill),
        .media_ack(media_ack), .media_fail(media_fail), .intrq(intrq));
    media_engine_model model (.clk_sys(clk_sys), .sys_rst(sys_rst), .media_req(media_req), .media_lba(media_lba),
        .fail_en(fail_en), .media_ack(media_ack), .media_fail(media_fail), .acks(acks),
        .lba_first(lba_first), .lba_last(lba_last));

    task final_report;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        tf_addr <= a;
        tf_wdata <= v;
        tf_wr <= 1'b1;
        @(posedge clk_sys);
        tf_wr <= 1'b0;
    endtask

    task rd(input logic [2:0] a);
        @(posedge clk_sys);
        tf_addr <= a;
        tf_rd <= 1'b1;
        @(posedge clk_sys);
        tf_rd <= 1'b0;
        #1 d = tf_rdata;
    endtask

    // polls status; a data request is fed one buffer of throwaway bytes
    task cmd(input logic [7:0] op);
        int i;
        wr(3'h7, op);
        for (i = 0; i < 2000; i++) begin
            rd(3'h7);
            if (d[3]) begin
                repeat (BUF) wr(3'h0, 8'($urandom));
            end else if (!d[7]) begin
                break;
            end
        end
        chk("command completion", i < 2000, 1);
    endtask

    task load_addr(input logic [27:0] a, input logic lba_mode, input logic [7:0] c);
        wr(3'h6, {1'b1, lba_mode, 2'b10, a[27:24]});
        wr(3'h5, a[23:16]);
        wr(3'h4, a[15:8]);
        wr(3'h3, a[7:0]);
        wr(3'h2, c);
    endtask

    function int secs(input logic [7:0] c);
        return (c == 8'h00) ? 256 : int'(c);
    endfunction

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            num_errors++;
            final_report;
        end
    end

    initial begin
        d = 8'($urandom(32'h14d42d0e));
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (int k = 0; k < 5; k++) begin
            rd(3'(ra[k]));
            chk("reset value", d, rv[k]);
        end
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys) sleep_state <= k[0];
            wr(3'h2, 8'($urandom) | 8'h01);
            cmd(k[1] ? 8'he5 : 8'h98);
            rd(3'h2);
            chk("power count", d, k[0] ? 8'h00 : 8'hff);
            chk("query irq", irqs, k + 1);
        end
        wr(3'h6, 8'ha0);
        for (int k = 0; k < 6; k++) begin
            @(posedge clk_sys) begin
                fault <= (k < 4) ? ((4'h1 << k) | (4'($urandom) & ~((4'h2 << k) - 4'h1))) : 4'h0;
                ide_mode <= (k == 5);
                slave_failed <= (k == 5);
            end
            cmd(8'h90);
            rd(3'h1);
            chk("diag code", d, (k < 4) ? 2 + k : ((k == 4) ? 8'h01 : 8'h81));
        end
        @(posedge clk_sys) ide_mode <= 1'b0;
        wr(3'h6, 8'hb0);
        wr(3'h7, 8'h90);
        repeat (12) @(posedge clk_sys);
        rd(3'h1);
        chk("diag unselected", d, 8'h81);
        @(posedge clk_sys) fault <= 4'h0;
        for (int k = 0; k < 5; k++) begin
            lba = 28'($urandom);
            cnt = (k == 0) ? 8'h00 : ((k == 2) ? 8'h01 : 8'(1 + $urandom % 4));
            @(posedge clk_sys) fail_en <= (k == 2);
            load_addr(lba, k != 4, (k == 3) ? 8'h02 : cnt);
            cmd((k < 3) ? 8'hc0 : 8'h50);
            chk("sector acks", acks, (k == 4) ? 1 : ((k == 3) ? 2 : secs(cnt)));
            chk("first address", lba_first, lba);
            if (k < 3) chk("last address", lba_last, lba + 28'(secs(cnt)) - 28'h1);
            rd(3'h7);
            chk("fault status", {d[5], d[0]}, (k == 2) ? 2'b11 : 2'b00);
        end
        @(posedge clk_sys) fail_en <= 1'b0;
        cmd(8'he7);
        chk("flush acks", acks, 1);
        rd(3'h7);
        chk("flush status", d, 8'h50);
        final_report;
    end
endmodule // tb_ata_command_handler

// [inc/ata_cmd_defs.vh]
/*
 * Task file offsets, opcodes, status/error bit positions and result codes
 * for the command execution block. Assumes an 8-bit task file port.
 */
`ifndef ATA_CMD_DEFS_VH
`define ATA_CMD_DEFS_VH

`define OFS_DATA 3'h0
`define OFS_FEATURE 3'h1
`define OFS_SECTOR_COUNT 3'h2
`define OFS_SECTOR_NUMBER 3'h3
`define OFS_CYLINDER_LOW 3'h4
`define OFS_CYLINDER_HIGH 3'h5
`define OFS_DRIVE_SELECT 3'h6
`define OFS_OPCODE 3'h7

`define OP_POWER_QUERY_A 8'h98
`define OP_POWER_QUERY_B 8'he5
`define OP_DIAGNOSE 8'h90
`define OP_ERASE 8'hc0
`define OP_FLUSH 8'he7
`define OP_FORMAT 8'h50

`define ST_BUSY 7
`define ST_READY 6
`define ST_WFAULT 5
`define ST_SEEKDONE 4
`define ST_DRQ 3
`define ST_ERR 0

`define ERR_ABORT 8'h04
`define ERR_NONE 8'h00
`define DIAG_OK 8'h01
`define DIAG_SLAVE_FAIL 8'h80

`define DS_LBA 6
`define DS_DRIVE 4
`define DS_ONES 8'ha0

`define PWR_SLEEP_RESULT 8'h00
`define PWR_IDLE_RESULT 8'hff
`define ZERO_COUNT 8'h00
`define FULL_COUNT 9'h100
`define STATUS_IDLE 8'h50

`endif
